// *** rtl/dvr_regs.sv ***
// DAC digital volume, master attenuation and first ADC control register bank.
// Assumes the serial control port delivers whole 9-bit writes as one-cycle
// strobes in the sys_clk domain and reads through a combinational address port.
// The tracking and zero-cross controls arrive as plain levels; the register
// that holds them lives elsewhere in the device, so this bank only reads them
// and never stores them.
`timescale 1ns/1ps
module dvr_regs (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic [6:0] reg_addr,
  input  wire logic [8:0] reg_wr_data,
  output logic [8:0]      reg_rd_data,
  input  wire logic       right_follows_left_atten,
  input  wire logic       volume_zero_cross_en,
  input  wire logic       dac_sample_valid,
  input  wire logic [5:0] dac_sample_sign,
  output logic [7:0]      dac1_left_atten,
  output logic [7:0]      dac1_right_atten,
  output logic [7:0]      dac2_left_atten,
  output logic [7:0]      dac2_right_atten,
  output logic [7:0]      dac3_left_atten,
  output logic [7:0]      dac3_right_atten,
  output logic [7:0]      master_atten,
  output logic [8:0]      dac1_left_steps,
  output logic [8:0]      dac1_right_steps,
  output logic [8:0]      dac2_left_steps,
  output logic [8:0]      dac2_right_steps,
  output logic [8:0]      dac3_left_steps,
  output logic [8:0]      dac3_right_steps,
  output logic            adc_left_silence,
  output logic            adc_right_silence,
  output logic            adc_both_silence,
  output logic            adc_oversample_select,
  output logic            adc_highpass_off
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Index 0..5 are the DAC channels in left/right pairs, index 6 is master.
  logic [6:0] vol_sel;
  logic [6:0] vol_wr;
  logic       adc_sel;
  logic       adc_wr;
  logic       update_strobe;
  logic [7:0] wr_code;

  assign vol_sel[0] = (reg_addr == dvr_pkg::DAC1_LEFT_VOLUME_OFS);
  assign vol_sel[1] = (reg_addr == dvr_pkg::DAC1_RIGHT_VOLUME_OFS);
  assign vol_sel[2] = (reg_addr == dvr_pkg::DAC2_LEFT_VOLUME_OFS);
  assign vol_sel[3] = (reg_addr == dvr_pkg::DAC2_RIGHT_VOLUME_OFS);
  assign vol_sel[4] = (reg_addr == dvr_pkg::DAC3_LEFT_VOLUME_OFS);
  assign vol_sel[5] = (reg_addr == dvr_pkg::DAC3_RIGHT_VOLUME_OFS);
  assign vol_sel[6] = (reg_addr == dvr_pkg::MASTER_VOLUME_OFS);
  assign adc_sel    = (reg_addr == dvr_pkg::ADC_CONTROL_FIRST_OFS);

  // One qualified strobe per register, so that a write to an address outside
  // this bank can never touch a latch.
  assign vol_wr[0] = reg_wr_en && vol_sel[0];
  assign vol_wr[1] = reg_wr_en && vol_sel[1];
  assign vol_wr[2] = reg_wr_en && vol_sel[2];
  assign vol_wr[3] = reg_wr_en && vol_sel[3];
  assign vol_wr[4] = reg_wr_en && vol_sel[4];
  assign vol_wr[5] = reg_wr_en && vol_sel[5];
  assign vol_wr[6] = reg_wr_en && vol_sel[6];
  assign adc_wr    = reg_wr_en && adc_sel;
  assign wr_code   = reg_wr_data[dvr_pkg::ATTEN_W-1:0];

  // ---------------------------------------------------------------------------
  // Update strobe
  // ---------------------------------------------------------------------------
  // The update bit is consumed here as a pulse and reaches no storage, so it
  // reads back as zero. A strobe on any volume address, the master included,
  // moves all seven channels together when zero-cross is off; with it on, each DAC channel moves at its own crossing, the master at any channel's.
  assign update_strobe = (|vol_wr) && reg_wr_data[dvr_pkg::UPDATE_BIT];

  // ---------------------------------------------------------------------------
  // Zero-crossing detection
  // ---------------------------------------------------------------------------
  logic [6:0] zc_hit;

  // All channels share one sample strobe. A channel whose sign never flips
  // keeps a deferred change waiting; clearing the zero-cross enable is the
  // way out of that.
  genvar gi;
  generate
    for (gi = 0; gi < dvr_pkg::NUM_DAC; gi = gi + 1)
    begin : g_zd
      dvr_zero_detect u_zd (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .sample_valid (dac_sample_valid),
        .sample_sign  (dac_sample_sign[gi]),
        .cross_hit    (zc_hit[gi])
      );
    end
  endgenerate

  // The master code feeds every channel, so any channel crossing releases it.
  assign zc_hit[6] = |zc_hit[5:0];

  // ---------------------------------------------------------------------------
  // Attenuation channels
  // ---------------------------------------------------------------------------
  logic [7:0] pending [0:6];
  logic [7:0] applied [0:6];

  // The write code fans out to all seven channels; only the selected latch
  // takes it, while the shared update strobe moves every channel at once with zero-cross off,
  // so that a stereo pair never plays at two different settings; with zero-cross on, each DAC channel waits for its own crossing, the master for any channel's.
  generate
    for (gi = 0; gi < dvr_pkg::NUM_ATTEN; gi = gi + 1)
    begin : g_ch
      dvr_atten_chan u_ch (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .latch_wr     (vol_wr[gi]),
        .wr_code      (wr_code),
        .update       (update_strobe),
        .zc_en        (volume_zero_cross_en),
        .zc_hit       (zc_hit[gi]),
        .pending_code (pending[gi]),
        .applied_code (applied[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Tracking and total attenuation
  // ---------------------------------------------------------------------------
  logic [7:0] eff_code [0:5];
  logic [8:0] steps    [0:5];
  logic [7:0] master_steps;

  // The master code is never tracked; it scales every channel alike, so its
  // steps are worked out once here and shared by all six sums below.
  assign master_steps = dvr_pkg::ATTEN_RESET - applied[6];

  generate
    for (gi = 0; gi < dvr_pkg::NUM_DAC; gi = gi + 1)
    begin : g_eff
      if ((gi % 2) == 1)
      begin : g_right
        // Tracking swaps in the left applied code; the right channel's own
        // programmed code is kept so that clearing tracking restores it.
        assign eff_code[gi] = right_follows_left_atten ? applied[gi-1]
                                                       : applied[gi];
      end
      else
      begin : g_left
        assign eff_code[gi] = applied[gi];
      end
    end
  endgenerate

  // Half-dB steps below full scale; channel and master add together, and the
  // ninth bit keeps a deep channel plus a deep master from wrapping.
  generate
    for (gi = 0; gi < dvr_pkg::NUM_DAC; gi = gi + 1)
    begin : g_steps
      assign steps[gi] = {1'b0, dvr_pkg::ATTEN_RESET - eff_code[gi]}
                         + {1'b0, master_steps};
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Registered attenuation outputs
  // ---------------------------------------------------------------------------
  logic [7:0] code_out_r  [0:6];
  logic [8:0] steps_out_r [0:5];

  // Codes and step totals both move on the edge after the apply, so the DAC
  // datapath never sees a code paired with a stale step total.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < dvr_pkg::NUM_DAC; i++)
        code_out_r[i] <= dvr_pkg::ATTEN_RESET;
      code_out_r[6] <= dvr_pkg::ATTEN_RESET;
    end
    else
    begin
      for (int i = 0; i < dvr_pkg::NUM_DAC; i++)
        code_out_r[i] <= eff_code[i];
      code_out_r[6] <= applied[6];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < dvr_pkg::NUM_DAC; i++)
        steps_out_r[i] <= 9'h000;
    end
    else
    begin
      for (int i = 0; i < dvr_pkg::NUM_DAC; i++)
        steps_out_r[i] <= steps[i];
    end
  end

  // ---------------------------------------------------------------------------
  // Output mapping
  // ---------------------------------------------------------------------------
  assign dac1_left_atten  = code_out_r[0];
  assign dac1_right_atten = code_out_r[1];
  assign dac2_left_atten  = code_out_r[2];
  assign dac2_right_atten = code_out_r[3];
  assign dac3_left_atten  = code_out_r[4];
  assign dac3_right_atten = code_out_r[5];
  assign master_atten     = code_out_r[6];

  assign dac1_left_steps  = steps_out_r[0];
  assign dac1_right_steps = steps_out_r[1];
  assign dac2_left_steps  = steps_out_r[2];
  assign dac2_right_steps = steps_out_r[3];
  assign dac3_left_steps  = steps_out_r[4];
  assign dac3_right_steps = steps_out_r[5];

  // ---------------------------------------------------------------------------
  // ADC control register
  // ---------------------------------------------------------------------------
  // Only the mute, oversampling and filter fields live here; the upper bits of
  // this address belong to other logic and read as zero from this bank.
  logic [4:0] adc_ctrl_r;
  logic [4:0] adc_ctrl_nxt;

  // Written whole: one write sets all five fields at once, and the bits above
  // them are dropped here rather than stored and masked later.
  assign adc_ctrl_nxt = reg_wr_data[dvr_pkg::ADC_STORED_W-1:0];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      adc_ctrl_r <= dvr_pkg::ADC_CTRL_RESET;
    else if (adc_wr)
      adc_ctrl_r <= adc_ctrl_nxt;
  end

  assign adc_left_silence      = adc_ctrl_r[dvr_pkg::ADC_LEFT_SIL_BIT];
  assign adc_right_silence     = adc_ctrl_r[dvr_pkg::ADC_RIGHT_SIL_BIT];
  assign adc_both_silence      = adc_ctrl_r[dvr_pkg::ADC_BOTH_SIL_BIT];
  assign adc_oversample_select = adc_ctrl_r[dvr_pkg::ADC_OSR_BIT];
  assign adc_highpass_off      = adc_ctrl_r[dvr_pkg::ADC_HPF_OFF_BIT];

  // ---------------------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------------------
  // Volume registers read the intermediate latch, i.e. the last code written,
  // which may not yet be applied.
  logic [8:0] vol_word [0:6];
  logic [8:0] adc_word;

  generate
    for (gi = 0; gi < dvr_pkg::NUM_ATTEN; gi = gi + 1)
    begin : g_rd
      assign vol_word[gi] = {1'b0, pending[gi]};
    end
  endgenerate

  assign adc_word = {4'h0, adc_ctrl_r};

  // Addresses outside the bank fall through to zero, and so do the ADC bits
  // above the stored fields.
  always_comb
  begin
    reg_rd_data = dvr_pkg::READ_UNMAPPED;
    if (vol_sel[0])
      reg_rd_data = vol_word[0];
    else if (vol_sel[1])
      reg_rd_data = vol_word[1];
    else if (vol_sel[2])
      reg_rd_data = vol_word[2];
    else if (vol_sel[3])
      reg_rd_data = vol_word[3];
    else if (vol_sel[4])
      reg_rd_data = vol_word[4];
    else if (vol_sel[5])
      reg_rd_data = vol_word[5];
    else if (vol_sel[6])
      reg_rd_data = vol_word[6];
    else if (adc_sel)
      reg_rd_data = adc_word;
  end

endmodule

// *** shared/dvr_pkg.sv ***
// Constants for the DAC volume and ADC mute register bank.
// Assumes a 7-bit register address and 9-bit register data from the control port.
package dvr_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 9;
  localparam int ATTEN_W    = 8;
  localparam int TOTAL_W    = 9;
  localparam int NUM_DAC    = 6;
  localparam int NUM_ATTEN  = 7;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [6:0] DAC1_LEFT_VOLUME_OFS  = 7'h14;
  localparam logic [6:0] DAC1_RIGHT_VOLUME_OFS = 7'h15;
  localparam logic [6:0] DAC2_LEFT_VOLUME_OFS  = 7'h16;
  localparam logic [6:0] DAC2_RIGHT_VOLUME_OFS = 7'h17;
  localparam logic [6:0] DAC3_LEFT_VOLUME_OFS  = 7'h18;
  localparam logic [6:0] DAC3_RIGHT_VOLUME_OFS = 7'h19;
  localparam logic [6:0] MASTER_VOLUME_OFS     = 7'h1C;
  localparam logic [6:0] ADC_CONTROL_FIRST_OFS = 7'h1D;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int UPDATE_BIT        = 8;
  localparam int ADC_LEFT_SIL_BIT  = 0;
  localparam int ADC_RIGHT_SIL_BIT = 1;
  localparam int ADC_BOTH_SIL_BIT  = 2;
  localparam int ADC_OSR_BIT       = 3;
  localparam int ADC_HPF_OFF_BIT   = 4;
  localparam int ADC_STORED_W      = 5;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ATTEN_RESET     = 8'hFF;
  localparam logic [4:0] ADC_CTRL_RESET  = 5'h00;
  localparam logic [8:0] READ_UNMAPPED   = 9'h000;

endpackage

// *** rtl/dvr_zero_detect.sv ***
// Zero-crossing detector for one DAC channel.
// Assumes sample_sign is valid whenever sample_valid is high.
`timescale 1ns/1ps
module dvr_zero_detect (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic sample_valid,
  input  wire logic sample_sign,
  output logic      cross_hit
);

  // ---------------------------------------------------------------------------
  // Sign history
  // ---------------------------------------------------------------------------
  logic sign_r;
  logic seen_r;

  // A crossing is a sign change between two accepted samples; the first
  // sample after reset only primes the history.
  assign cross_hit = sample_valid && seen_r && (sample_sign != sign_r);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sign_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else if (sample_valid)
    begin
      sign_r <= sample_sign;
      seen_r <= 1'b1;
    end
  end

endmodule

// *** rtl/dvr_atten_chan.sv ***
// One attenuation channel: intermediate latch plus applied code.
// Assumes latch_wr and update are one-cycle strobes from the register decode.
`timescale 1ns/1ps
module dvr_atten_chan (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       latch_wr,
  input  wire logic [7:0] wr_code,
  input  wire logic       update,
  input  wire logic       zc_en,
  input  wire logic       zc_hit,
  output logic [7:0]      pending_code,
  output logic [7:0]      applied_code
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0] pending_r;
  logic [7:0] applied_r;
  logic [7:0] staged_r;
  logic       armed_r;
  logic [7:0] target;
  logic       apply_now;
  logic       apply_staged;

  // A write that carries the strobe applies its own code, not the stale latch.
  assign target       = latch_wr ? wr_code : pending_r;
  assign apply_now    = update && !zc_en;
  // Dropping the zero-cross enable releases a held change at once.
  assign apply_staged = !update && armed_r && (zc_hit || !zc_en);

  assign pending_code = pending_r;
  assign applied_code = applied_r;

  // ---------------------------------------------------------------------------
  // Latch and apply
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pending_r <= dvr_pkg::ATTEN_RESET;
      applied_r <= dvr_pkg::ATTEN_RESET;
      staged_r  <= dvr_pkg::ATTEN_RESET;
      armed_r   <= 1'b0;
    end
    else
    begin
      if (latch_wr)
        pending_r <= wr_code;
      if (apply_now)
      begin
        applied_r <= target;
        // A direct apply supersedes anything still held for a crossing, or the
        // stale held code would overwrite it on the next edge.
        armed_r   <= 1'b0;
      end
      else if (apply_staged)
      begin
        applied_r <= staged_r;
        armed_r   <= 1'b0;
      end
      // A new update while one is held replaces the held value.
      if (update && zc_en)
      begin
        staged_r <= target;
        armed_r  <= 1'b1;
      end
    end
  end

endmodule

// *** verif/dvr_regs_asserts.sv ***
// Port assertions for the volume and ADC control register bank.
// Assumes one clock domain, sys_clk, with rst asynchronous and active high.
`timescale 1ns/1ps
module dvr_regs_asserts (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       reg_wr_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wr_data,
  input wire logic       right_follows_left_atten,
  input wire logic       volume_zero_cross_en,
  input wire logic       dac_sample_valid,
  input wire logic [7:0] dac1_left_atten,
  input wire logic [7:0] dac1_right_atten,
  input wire logic [7:0] master_atten,
  input wire logic [8:0] dac1_left_steps,
  input wire logic       adc_left_silence,
  input wire logic       adc_right_silence,
  input wire logic       adc_both_silence,
  input wire logic       adc_oversample_select,
  input wire logic       adc_highpass_off
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic vol_wr = reg_wr_en && ((reg_addr >= 7'h14 && reg_addr <= 7'h19) || reg_addr == 7'h1C);
  wire logic upd    = vol_wr && reg_wr_data[8];
  wire logic adc_wr = reg_wr_en && reg_addr == 7'h1D;
  wire logic upd_ok = upd && !volume_zero_cross_en;
  property p_rst_codes;
    $fell(rst) |-> dac1_left_atten == 8'hFF && master_atten == 8'hFF;
  endproperty
  property p_hold;
    (!volume_zero_cross_en [*3]) ##0 (vol_wr && !reg_wr_data[8])
      |=> ##1 $stable(master_atten) && $stable(dac1_left_atten);
  endproperty
  property p_upd_chan;
    upd_ok && reg_addr == 7'h14 |-> ##2 dac1_left_atten == $past(reg_wr_data[7:0], 2);
  endproperty
  property p_upd_master;
    upd_ok && reg_addr == 7'h1C |-> ##2 master_atten == $past(reg_wr_data[7:0], 2);
  endproperty
  // The step total is the sum of both attenuations, so full-scale codes on both give zero.
  property p_steps;
    dac1_left_steps == {1'b0, ~dac1_left_atten} + {1'b0, ~master_atten};
  endproperty
  property p_track;
    right_follows_left_atten [*3] |-> dac1_right_atten == dac1_left_atten;
  endproperty
  property p_zc;
    (volume_zero_cross_en && !dac_sample_valid) [*3] |-> $stable(master_atten);
  endproperty
  property p_adc_sil;
    adc_wr |=> {adc_both_silence, adc_right_silence, adc_left_silence} == $past(reg_wr_data[2:0]);
  endproperty
  property p_adc_osr;
    adc_wr |=> adc_oversample_select == $past(reg_wr_data[3]);
  endproperty
  property p_adc_hpf;
    adc_wr |=> adc_highpass_off == $past(reg_wr_data[4]);
  endproperty
  a_rst_codes: assert property (p_rst_codes) else $error("codes not full scale");
  a_hold: assert property (p_hold) else $error("code moved without update");
  a_upd_chan: assert property (p_upd_chan) else $error("channel code not applied");
  a_upd_master: assert property (p_upd_master) else $error("master not applied");
  a_steps: assert property (p_steps) else $error("step total wrong");
  a_track: assert property (p_track) else $error("right not tracking left");
  a_zc: assert property (p_zc) else $error("change before crossing");
  a_adc_sil: assert property (p_adc_sil) else $error("silence bits wrong");
  a_adc_osr: assert property (p_adc_osr) else $error("oversample bit wrong");
  a_adc_hpf: assert property (p_adc_hpf) else $error("highpass bit wrong");
  c_upd_zc: cover property (upd && volume_zero_cross_en);
  c_upd_trk: cover property (upd && right_follows_left_atten);
  c_adc: cover property (adc_wr);
endmodule

bind dvr_regs dvr_regs_asserts chk_u (.sys_clk, .rst, .reg_wr_en, .reg_addr, .reg_wr_data,
  .right_follows_left_atten, .volume_zero_cross_en, .dac_sample_valid, .dac1_left_atten,
  .dac1_right_atten, .master_atten, .dac1_left_steps, .adc_left_silence, .adc_right_silence,
  .adc_both_silence, .adc_oversample_select, .adc_highpass_off);

// *** verif/dvr_host_model.sv ***
// Host controller model: issues whole 9-bit register writes and read addresses.
// Assumes the bench calls its tasks; all changes land at the falling edge.
`timescale 1ns/1ps
module dvr_host_model (
  input wire logic sys_clk,
  output logic       reg_wr_en,
  output logic [6:0] reg_addr,
  output logic [8:0] reg_wr_data
);
  initial
  begin
    reg_wr_en   = 1'b0;
    reg_addr    = 7'h00;
    reg_wr_data = 9'h000;
  end
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge sys_clk);
    reg_wr_en   = 1'b1;
    reg_addr    = a;
    reg_wr_data = d;
    @(negedge sys_clk);
    reg_wr_en   = 1'b0;
    // Released data is inverted so a stale word can never pass for a new one.
    reg_wr_data = ~d;
  endtask
  task automatic sel(input logic [6:0] a);
    @(negedge sys_clk);
    reg_addr = a;
  endtask
endmodule

// *** verif/dac_volume_adc_mute_regs_tb.sv ***
// Self-checking bench for the volume and ADC control register bank.
// Assumes the host model drives the register port; samples come from here.
`timescale 1ns/1ps
module dac_volume_adc_mute_regs_tb;
  logic        sys_clk, rst, trk, zc, sval, reg_wr_en;
  logic [5:0]  ssign;
  logic [6:0]  reg_addr;
  logic [8:0]  reg_wr_data, reg_rd_data, st [6];
  logic [7:0]  at [7], pend [7], appl [7];
  logic [4:0]  adc;
  logic [31:0] seed, r;
  int          n_errors, checks;
  dvr_host_model host_u (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data));
  dvr_regs dut_u (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .right_follows_left_atten(trk),
    .volume_zero_cross_en(zc), .dac_sample_valid(sval), .dac_sample_sign(ssign),
    .dac1_left_atten(at[0]), .dac1_right_atten(at[1]), .dac2_left_atten(at[2]),
    .dac2_right_atten(at[3]), .dac3_left_atten(at[4]), .dac3_right_atten(at[5]),
    .master_atten(at[6]), .dac1_left_steps(st[0]), .dac1_right_steps(st[1]),
    .dac2_left_steps(st[2]), .dac2_right_steps(st[3]), .dac3_left_steps(st[4]),
    .dac3_right_steps(st[5]), .adc_left_silence(adc[0]), .adc_right_silence(adc[1]),
    .adc_both_silence(adc[2]), .adc_oversample_select(adc[3]), .adc_highpass_off(adc[4]));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] adr(input int i);
    return (i < 6) ? 7'h14 + 7'(i) : 7'h1C;
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    host_u.sel(a);
    #1;
    cmp(reg_rd_data, exp);
  endtask
  task automatic vol(input int i, input logic [8:0] d);
    host_u.wr(adr(i), d);
    pend[i] = d[7:0];
    // With zero-cross on, an update is only staged; the expectation moves at the crossing.
    if (d[8] && !zc) appl = pend;
  endtask
  task automatic chk_out();
    logic [7:0] e;
    @(negedge sys_clk);
    for (int i = 0; i < 7; i++)
    begin
      e = (trk && i < 6 && i[0]) ? appl[i-1] : appl[i];
      cmp({1'b0, at[i]}, {1'b0, e});
      if (i < 6) cmp(st[i], {1'b0, ~e} + {1'b0, ~appl[6]});
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    #2ms;
    n_errors++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial
  begin
    {rst, trk, zc, sval, ssign} = {4'h8, 6'h00};
    seed = 32'h000122A3;
    n_errors = 0;
    checks = 0;
    for (int i = 0; i < 7; i++) {pend[i], appl[i]} = 16'hFFFF;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) rd(adr(i), 9'h0FF);
    rd(7'h1D, 9'h000);
    rd(7'h1A, 9'h000);
    chk_out();
    for (int i = 0; i < 7; i++)
    begin
      r = rnd();
      vol(i, {1'b0, r[7:0]});
    end
    chk_out();
    for (int i = 0; i < 7; i++) rd(adr(i), {1'b0, pend[i]});
    for (int i = 0; i < 7; i++)
    begin
      r = rnd();
      vol(i, {1'b1, r[7:0]});
      chk_out();
      rd(adr(i), {1'b0, pend[i]});
    end
    vol(6, 9'h100);
    vol(0, 9'h1FF);
    chk_out();
    trk = 1'b1;
    r = rnd();
    vol(2, {1'b1, r[7:0]});
    chk_out();
    trk = 1'b0;
    chk_out();
    for (int v = 0; v < 32; v++)
    begin
      r = rnd();
      host_u.wr(7'h1D, {r[3:0], 5'(v)});
      cmp({4'h0, adc}, 9'(v));
      rd(7'h1D, 9'(v));
    end
    host_u.wr(7'h1A, 9'h1AA);
    rd(7'h1A, 9'h000);
    chk_out();
    zc = 1'b1;
    r = rnd();
    vol(6, {1'b1, r[7:0]});
    vol(3, {1'b1, r[15:8]});
    chk_out();
    @(negedge sys_clk);
    sval = 1'b1;
    @(negedge sys_clk);
    ssign = 6'h3F;
    @(negedge sys_clk);
    sval = 1'b0;
    appl = pend;
    chk_out();
    zc = 1'b0;
    tally_and_finish();
  end
endmodule
